// >>> sws_core.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "sws_consts.svh"
module sws_core (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        instr_valid,
    output logic             instr_issue,
    input  wire logic [4:0]  instr_src_a,
    input  wire logic [4:0]  instr_src_b,
    input  wire logic [4:0]  instr_dst,
    input  wire logic        instr_multi,
    input  wire logic        instr_mem,
    input  wire logic        instr_load,
    input  wire logic        instr_imm_sel,
    input  wire logic [15:0] instr_imm,
    input  wire logic        instr_call,
    output logic      [31:0] source_bus_a,
    output logic      [31:0] source_bus_b,
    input  wire logic        int_wb_req,
    input  wire logic [4:0]  int_wb_dst,
    input  wire logic [31:0] int_wb_data,
    output logic             int_wb_gnt,
    input  wire logic        fpu_wb_req,
    input  wire logic [4:0]  fpu_wb_dst,
    input  wire logic [31:0] fpu_wb_data,
    output logic             fpu_wb_gnt,
    output logic             result_valid,
    output logic      [4:0]  result_dst,
    output logic      [31:0] result_data,
    output logic             d_req,
    output logic      [29:0] d_addr,
    output logic             d_we,
    output logic      [31:0] d_wdata,
    input  wire logic        d_reply,
    input  wire logic        d_reply_err,
    input  wire logic [31:0] d_rdata,
    output logic             d_reply_ack,
    input  wire logic        exc_precise,
    input  wire logic        exc_irq,
    input  wire logic        exc_imprecise,
    output logic             exc_ack,
    output logic             context_freeze,
    output logic             fpu_disable,
    input  wire logic        branch_taken,
    input  wire logic [31:0] branch_target,
    output logic             prefetch_flush,
    output logic             prefetch_load,
    output logic      [31:0] execute_pointer,
    output logic      [31:0] decode_pointer,
    output logic      [31:0] prefetch_pointer
);
    logic [31:0]          regfile_q [0:31];
    logic [31:0]          sb_q;
    logic [31:0]          durec_q [0:`SWS_DUREC_NUM-1];
    logic [31:0]          vbase_q;
    logic                 delay_q;
    logic                 ack_q;
    sws_pkg::sws_state_t  state_q;
    sws_pkg::sws_cause_t  cause_q;
    logic                 mem_err_q;
    logic                 call_pend_q;
    logic [31:0]          call_ret_q;
    logic                 s2_v_q, s2_ld_q, s1_v_q, s1_ld_q, s0_v_q, s0_ld_q;
    logic [4:0]           s2_reg_q, s1_reg_q, s0_reg_q;
    logic [31:0]          s2_addr_q;
    logic                 du_wb_v_q;
    logic [4:0]           du_wb_dst_q;
    logic [31:0]          du_wb_data_q;
    logic                 flush_q, load_q, exc_ack_q;
    logic                 exc_any, exc_block, int_any, du_gnt, call_gnt;
    logic                 busy_a, busy_b, busy_d, mem_ok, s1_go, s0_done, pipe_empty;
    logic [31:0]          rd_a, rd_b, rd_st, vec_addr;
    logic [31:0]          sb_set, sb_clr;
    sws_pkg::sws_cause_t  cause_d;

    // ---------------- register bus: one wait cycle, then answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            delay_q <= 1'b0;
            vbase_q <= `SWS_RESET_VBASE;
        end else if (avs_write && ack_q) begin
            if (avs_address == `SWS_OFS_CTRL) begin
                delay_q <= avs_writedata[`SWS_CTRL_DELAY];
            end
            if (avs_address == `SWS_OFS_VBASE) begin
                vbase_q <= avs_writedata & `SWS_PAGE_MASK;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            avs_readdata <= 32'h0000_0000;
            unique case (avs_address)
                `SWS_OFS_CTRL:   avs_readdata <= {31'h0000_0000, delay_q};
                `SWS_OFS_VBASE:  avs_readdata <= vbase_q;
                `SWS_OFS_SCORE:  avs_readdata <= sb_q;
                `SWS_OFS_EXECP:  avs_readdata <= execute_pointer;
                `SWS_OFS_DECP:   avs_readdata <= decode_pointer;
                `SWS_OFS_PREFP:  avs_readdata <= prefetch_pointer;
                `SWS_OFS_STATUS: avs_readdata <= {22'h00_0000, mem_err_q, du_wb_v_q, s0_v_q, s1_v_q, s2_v_q,
                                                  call_pend_q, cause_q, state_q};
                default: begin
                    if (avs_address >= `SWS_OFS_DUREC && avs_address < `SWS_OFS_DUREC + 8'(4 * `SWS_DUREC_NUM)
                        && avs_address[1:0] == 2'b00) begin
                        avs_readdata <= durec_q[4'((avs_address - `SWS_OFS_DUREC) >> 2)];
                    end
                end
            endcase
        end
    end

    // ---------------- writeback arbiter
    assign exc_any   = exc_precise | exc_irq | exc_imprecise | mem_err_q;
    assign exc_block = exc_any | (state_q != sws_pkg::SWS_RUN);
    assign int_any   = call_pend_q | int_wb_req;
    // only one result per cycle; losers keep their request up
    assign call_gnt   = !exc_block && call_pend_q;
    assign int_wb_gnt = !exc_block && !call_pend_q && int_wb_req;
    assign fpu_wb_gnt = !exc_block && !int_any && fpu_wb_req;
    assign du_gnt     = du_wb_v_q && (exc_block || (!int_any && !fpu_wb_req));

    always_comb begin
        result_valid = call_gnt | int_wb_gnt | fpu_wb_gnt | du_gnt;
        result_dst   = 5'h00;
        result_data  = 32'h0000_0000;
        if (call_gnt) begin
            result_dst  = `SWS_RET_REG;
            result_data = call_ret_q;
        end else if (int_wb_gnt) begin
            result_dst  = int_wb_dst;
            result_data = int_wb_data;
        end else if (fpu_wb_gnt) begin
            result_dst  = fpu_wb_dst;
            result_data = fpu_wb_data;
        end else if (du_gnt) begin
            result_dst  = du_wb_dst_q;
            result_data = du_wb_data_q;
        end
    end

    always_ff @(posedge clk) begin
        if (result_valid && result_dst != 5'h00) begin
            regfile_q[result_dst] <= result_data;
        end
    end

    // ---------------- read ports with feed-forward from the result bus
    function automatic logic [31:0] sws_read(input logic [4:0] idx, input logic v, input logic [4:0] wd,
                                             input logic [31:0] wdat, input logic [31:0] rfv);
        sws_read = 32'h0000_0000;
        if (idx != 5'h00) begin
            sws_read = (v && wd == idx) ? wdat : rfv;
        end
    endfunction

    assign rd_a  = sws_read(instr_src_a, result_valid, result_dst, result_data, regfile_q[instr_src_a]);
    assign rd_b  = sws_read(instr_src_b, result_valid, result_dst, result_data, regfile_q[instr_src_b]);
    assign rd_st = sws_read(s2_reg_q, result_valid, result_dst, result_data, regfile_q[s2_reg_q]);

    // a register being written this cycle counts as free: its value is forwarded
    assign busy_a = sb_q[instr_src_a] && !(result_valid && result_dst == instr_src_a);
    assign busy_b = sb_q[instr_src_b] && !(result_valid && result_dst == instr_src_b);
    assign busy_d = sb_q[instr_dst] && !(result_valid && result_dst == instr_dst);

    // ---------------- issue
    assign mem_ok      = !s2_v_q || !s1_v_q || s1_go;
    assign instr_issue = instr_valid && !exc_block && !busy_a && !busy_b && !busy_d
                         && (!instr_mem || mem_ok) && !(instr_call && call_pend_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            source_bus_a <= 32'h0000_0000;
            source_bus_b <= 32'h0000_0000;
        end else if (instr_issue) begin
            source_bus_a <= rd_a;
            source_bus_b <= rd_b;
        end
    end

    // ---------------- scoreboard; a set wins over a clear of the same bit
    always_comb begin
        sb_set = 32'h0000_0000;
        sb_clr = 32'h0000_0000;
        if (instr_issue && (instr_multi || (instr_mem && instr_load))) begin
            sb_set[instr_dst] = 1'b1;
        end
        if (instr_issue && instr_call) begin
            sb_set[`SWS_RET_REG] = 1'b1;
        end
        if (result_valid) begin
            sb_clr[result_dst] = 1'b1;
        end
        if (s0_done && s0_ld_q && d_reply_err) begin
            sb_clr[s0_reg_q] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sb_q <= 32'h0000_0000;
        end else begin
            sb_q <= ((sb_q & ~sb_clr) | sb_set) & 32'hFFFF_FFFE;
        end
    end

    // ---------------- call return pointer, written as a single-cycle result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            call_pend_q <= 1'b0;
            call_ret_q  <= 32'h0000_0000;
        end else if (instr_issue && instr_call) begin
            call_pend_q <= 1'b1;
            call_ret_q  <= delay_q ? prefetch_pointer : decode_pointer;
        end else if (call_gnt) begin
            call_pend_q <= 1'b0;
        end
    end

    // ---------------- data memory pipeline
    // stage 0 retires only when its load result has a slot to wait in
    assign s0_done     = s0_v_q && d_reply && (!s0_ld_q || d_reply_err || !du_wb_v_q || du_gnt);
    assign d_reply_ack = s0_done;
    assign s1_go       = s1_v_q && (!s0_v_q || s0_done);
    assign pipe_empty  = !s2_v_q && !s1_v_q && !s0_v_q && !du_wb_v_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s2_v_q    <= 1'b0;
            s2_ld_q   <= 1'b0;
            s2_reg_q  <= 5'h00;
            s2_addr_q <= 32'h0000_0000;
        end else if (instr_issue && instr_mem) begin
            s2_v_q    <= 1'b1;
            s2_ld_q   <= instr_load;
            s2_reg_q  <= instr_dst;
            s2_addr_q <= rd_a + (instr_imm_sel ? {16'h0000, instr_imm} : rd_b);
        end else if (s2_v_q && (!s1_v_q || s1_go)) begin
            s2_v_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_v_q   <= 1'b0;
            s1_ld_q  <= 1'b0;
            s1_reg_q <= 5'h00;
            d_addr   <= 30'h0000_0000;
            d_wdata  <= 32'h0000_0000;
        end else if (s2_v_q && (!s1_v_q || s1_go)) begin
            s1_v_q   <= 1'b1;
            s1_ld_q  <= s2_ld_q;
            s1_reg_q <= s2_reg_q;
            d_addr   <= s2_addr_q[31:2];
            d_wdata  <= s2_ld_q ? 32'h0000_0000 : rd_st;
        end else if (s1_go) begin
            s1_v_q <= 1'b0;
        end
    end
    assign d_req = s1_v_q;
    assign d_we  = s1_v_q && !s1_ld_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s0_v_q   <= 1'b0;
            s0_ld_q  <= 1'b0;
            s0_reg_q <= 5'h00;
        end else if (s1_go) begin
            s0_v_q   <= 1'b1;
            s0_ld_q  <= s1_ld_q;
            s0_reg_q <= s1_reg_q;
        end else if (s0_done) begin
            s0_v_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            du_wb_v_q    <= 1'b0;
            du_wb_dst_q  <= 5'h00;
            du_wb_data_q <= 32'h0000_0000;
        end else if (s0_done && s0_ld_q && !d_reply_err) begin
            du_wb_v_q    <= 1'b1;
            du_wb_dst_q  <= s0_reg_q;
            du_wb_data_q <= d_rdata;
        end else if (du_gnt) begin
            du_wb_v_q <= 1'b0;
        end
    end

    // faulting access and those behind it, kept for rebuild
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `SWS_DUREC_NUM; i++) begin
                durec_q[i] <= 32'h0000_0000;
            end
        end else if (s0_done && d_reply_err) begin
            durec_q[0] <= {24'h00_0000, 1'b1, s0_ld_q, 1'b0, s0_reg_q};
            durec_q[1] <= {d_addr, 2'b00};
            durec_q[2] <= d_rdata;
            durec_q[3] <= {24'h00_0000, s1_v_q, s1_ld_q, 1'b0, s1_reg_q};
            durec_q[4] <= {d_addr, 2'b00};
            durec_q[5] <= d_wdata;
            durec_q[6] <= {24'h00_0000, s2_v_q, s2_ld_q, 1'b0, s2_reg_q};
            durec_q[7] <= s2_addr_q;
            durec_q[8] <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_err_q <= 1'b0;
        end else if (s0_done && d_reply_err) begin
            mem_err_q <= 1'b1;
        end else if (state_q == sws_pkg::SWS_VECTOR && cause_q == sws_pkg::SWS_EXC_IMPRECISE) begin
            mem_err_q <= 1'b0;
        end
    end

    // ---------------- exception arbiter and sequence
    always_comb begin
        if (exc_precise) begin
            cause_d = sws_pkg::SWS_EXC_PRECISE;
        end else if (exc_irq) begin
            cause_d = sws_pkg::SWS_EXC_INTERRUPT;
        end else if (exc_imprecise || mem_err_q) begin
            cause_d = sws_pkg::SWS_EXC_IMPRECISE;
        end else begin
            cause_d = sws_pkg::SWS_EXC_NONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sws_pkg::SWS_RUN;
            cause_q <= sws_pkg::SWS_EXC_NONE;
        end else begin
            unique case (state_q)
                sws_pkg::SWS_RUN: begin
                    // requests still seen in the ack cycle were already served
                    if (exc_any && !exc_ack_q) begin
                        state_q <= sws_pkg::SWS_DRAIN;
                        cause_q <= cause_d;
                    end
                end
                sws_pkg::SWS_DRAIN: begin
                    if (pipe_empty) begin
                        state_q <= sws_pkg::SWS_FREEZE;
                    end
                end
                sws_pkg::SWS_FREEZE: state_q <= sws_pkg::SWS_VECTOR;
                sws_pkg::SWS_VECTOR: state_q <= sws_pkg::SWS_RUN;
            endcase
        end
    end
    assign context_freeze = state_q == sws_pkg::SWS_FREEZE || state_q == sws_pkg::SWS_VECTOR;
    assign fpu_disable    = state_q != sws_pkg::SWS_RUN;
    assign vec_addr       = vbase_q + (32'(cause_q) << `SWS_VEC_SHIFT);

    // ---------------- instruction pointers and prefetch control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            execute_pointer  <= `SWS_RESET_PC;
            decode_pointer   <= `SWS_RESET_PC;
            prefetch_pointer <= `SWS_RESET_PC;
            flush_q          <= 1'b0;
            load_q           <= 1'b0;
            exc_ack_q        <= 1'b0;
        end else begin
            flush_q   <= 1'b0;
            load_q    <= 1'b0;
            exc_ack_q <= 1'b0;
            if (state_q == sws_pkg::SWS_VECTOR) begin
                prefetch_pointer <= vec_addr;
                flush_q          <= 1'b1;
                load_q           <= 1'b1;
                exc_ack_q        <= 1'b1;
            end else if (instr_issue) begin
                execute_pointer <= decode_pointer;
                decode_pointer  <= prefetch_pointer;
                if (branch_taken) begin
                    prefetch_pointer <= branch_target;
                    flush_q          <= 1'b1;
                    load_q           <= 1'b1;
                end else begin
                    prefetch_pointer <= prefetch_pointer + `SWS_PTR_STEP;
                end
            end
        end
    end
    assign prefetch_flush = flush_q;
    assign prefetch_load  = load_q;
    assign exc_ack        = exc_ack_q;

    // ---------------- checks
    a_zero_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
        instr_issue && instr_src_a == 5'h00 |=> source_bus_a == 32'h0000_0000)
        else $error("zero register read non-zero");
    a_wb_one_grant: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0({call_gnt, int_wb_gnt, fpu_wb_gnt, du_gnt}))
        else $error("more than one writeback grant");
    a_wb_exc_mem_only: assert property (@(posedge clk) disable iff (!rst_n)
        exc_block |-> !call_gnt && !int_wb_gnt && !fpu_wb_gnt)
        else $error("non-memory writeback during exception");
    a_wb_priority: assert property (@(posedge clk) disable iff (!rst_n)
        !exc_block && int_wb_req && !call_pend_q |-> int_wb_gnt && !fpu_wb_gnt && !du_gnt)
        else $error("writeback priority violated");
    a_busy_marked: assert property (@(posedge clk) disable iff (!rst_n)
        instr_issue && instr_multi && instr_dst != 5'h00 |=> sb_q[$past(instr_dst)])
        else $error("destination not marked busy");
    a_exc_order: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sws_pkg::SWS_RUN && !exc_ack && exc_precise |=> cause_q == sws_pkg::SWS_EXC_PRECISE)
        else $error("exception priority violated");
    a_freeze_drained: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(context_freeze) |-> pipe_empty && fpu_disable)
        else $error("freeze before memory drained");
    a_vector_load: assert property (@(posedge clk) disable iff (!rst_n)
        state_q == sws_pkg::SWS_VECTOR |=> prefetch_pointer == $past(vec_addr) && prefetch_flush ##1 !prefetch_flush)
        else $error("vector not loaded into prefetch pointer");
    a_addr_stage: assert property (@(posedge clk) disable iff (!rst_n)
        s2_v_q && (!s1_v_q || s1_go) |=> d_req && d_addr == $past(s2_addr_q[31:2]))
        else $error("address not driven in next stage");
    a_forward_a: assert property (@(posedge clk) disable iff (!rst_n)
        instr_issue && result_valid && result_dst == instr_src_a && instr_src_a != 5'h00
        |=> source_bus_a == $past(result_data))
        else $error("result not forwarded");
    c_two_on_bus: cover property (@(posedge clk) disable iff (!rst_n) s1_v_q && s0_v_q);
    c_exc_sequence: cover property (@(posedge clk) disable iff (!rst_n)
        state_q == sws_pkg::SWS_DRAIN ##[1:40] state_q == sws_pkg::SWS_VECTOR);
    c_fwd_both: cover property (@(posedge clk) disable iff (!rst_n)
        instr_issue && result_valid && result_dst == instr_src_a && result_dst == instr_src_b);
endmodule
`default_nettype wire

// >>> sws_consts.svh
`ifndef SWS_CONSTS_SVH
`define SWS_CONSTS_SVH
// register byte offsets
`define SWS_OFS_CTRL     8'h00
`define SWS_OFS_VBASE    8'h04
`define SWS_OFS_SCORE    8'h08
`define SWS_OFS_EXECP    8'h0C
`define SWS_OFS_DECP     8'h10
`define SWS_OFS_PREFP    8'h14
`define SWS_OFS_STATUS   8'h18
`define SWS_OFS_DUREC    8'h40
`define SWS_DUREC_NUM    9
// fields and values
`define SWS_CTRL_DELAY   0
`define SWS_RESET_PC     32'h0000_0000
`define SWS_RESET_VBASE  32'h0000_0000
`define SWS_PAGE_MASK    32'hFFFF_F000
`define SWS_RET_REG      5'h01
`define SWS_PTR_STEP     32'h0000_0004
`define SWS_VEC_SHIFT    3
`endif

// >>> sws_pkg.sv
package sws_pkg;
    typedef enum logic [1:0] {
        SWS_RUN    = 2'b00,
        SWS_DRAIN  = 2'b01,
        SWS_FREEZE = 2'b10,
        SWS_VECTOR = 2'b11
    } sws_state_t;
    typedef enum logic [1:0] {
        SWS_EXC_NONE      = 2'b00,
        SWS_EXC_PRECISE   = 2'b01,
        SWS_EXC_INTERRUPT = 2'b10,
        SWS_EXC_IMPRECISE = 2'b11
    } sws_cause_t;
endpackage

// >>> sws_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module sws_mem_model (
    input  wire logic        clk,
    input  wire logic        d_req,
    input  wire logic [29:0] d_addr,
    input  wire logic        d_reply_ack,
    output logic             d_reply,
    output logic      [31:0] d_rdata
);
    logic        occ_q = 1'b0;
    logic [29:0] adr_q;
    initial d_reply = 1'b0;
    initial d_rdata = 32'h0;
    // oldest access only; a new one enters as the old one is acked
    always @(posedge clk) begin
        if (d_req && (!occ_q || d_reply_ack)) begin
            occ_q <= 1'b1;
            adr_q <= d_addr;
        end else if (d_reply_ack) begin
            occ_q <= 1'b0;
        end
        if (d_reply && !d_reply_ack) begin
        end else if (occ_q && !d_reply_ack && $urandom_range(1) == 0) begin
            d_reply <= 1'b1;
            d_rdata <= {adr_q, 2'b00} ^ 32'hA5A5_0000;
        end else begin
            // no stale data between replies
            d_reply <= 1'b0;
            d_rdata <= ~d_rdata;
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, instr_valid = 1'b0;
    logic        instr_multi = 1'b0, instr_mem = 1'b0, instr_load = 1'b0, instr_imm_sel = 1'b0;
    logic        instr_call = 1'b0, int_wb_req = 1'b0, fpu_wb_req = 1'b0, d_reply_err = 1'b0;
    logic        exc_precise = 1'b0, exc_irq = 1'b0, exc_imprecise = 1'b0, branch_taken = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic [4:0]  instr_src_a = 5'h0, instr_src_b = 5'h0, instr_dst = 5'h0, int_wb_dst = 5'h7, fpu_wb_dst = 5'h8;
    logic [15:0] instr_imm = 16'h0;
    logic [31:0] avs_writedata = 32'h0, int_wb_data = 32'h0, fpu_wb_data = 32'h0, branch_target = 32'h0;
    logic        avs_waitrequest, instr_issue, int_wb_gnt, fpu_wb_gnt, result_valid, d_req, d_we;
    logic        d_reply, d_reply_ack, exc_ack, context_freeze, fpu_disable, prefetch_flush, prefetch_load;
    logic [4:0]  result_dst;
    logic [29:0] d_addr;
    logic [31:0] avs_readdata, source_bus_a, source_bus_b, result_data, d_wdata, d_rdata, rd, ld;
    logic [31:0] execute_pointer, decode_pointer, prefetch_pointer;
    int          err_total = 0, check_count = 0;
    initial forever #10 clk = ~clk;
    sws_core sws_core_i (.*);
    sws_mem_model sws_mem_model_i (.clk(clk), .d_req(d_req), .d_addr(d_addr), .d_reply_ack(d_reply_ack),
                                   .d_reply(d_reply), .d_rdata(d_rdata));
    function automatic logic [31:0] cause(input logic [2:0] m);
        return m[0] ? 32'h1 : (m[1] ? 32'h2 : 32'h3);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // level checks at negedge, where combinational outputs have settled
    task automatic see(ref logic s);
        while (s !== 1'b1) @(negedge clk);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= w;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic issue(input logic [4:0] a, input logic [4:0] d, input logic m, input logic [15:0] im);
        @(posedge clk);
        instr_src_a   <= a;
        instr_src_b   <= 5'($urandom);
        instr_dst     <= d;
        {instr_mem, instr_load, instr_imm_sel} <= {3{m}};
        instr_imm     <= im;
        instr_valid   <= 1'b1;
        @(negedge clk);
        see(instr_issue);
        @(posedge clk);
        instr_valid <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h9A37));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b1, 8'h04, 32'h1234_5FFF);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h1234_5000);
        bus(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        for (int i = 2; i < 6; i++) begin
            ld = (i == 5) ? 32'hFFFF : $urandom;
            issue(5'h0, 5'(i), 1'b1, ld[15:0]);
            see(d_req);
            chk({2'b00, d_addr}, {18'h0, ld[15:2]});
            see(result_valid);
            chk(result_data, {16'h0, ld[15:2], 2'b00} ^ 32'hA5A5_0000);
            chk({27'h0, result_dst}, 32'(i));
        end
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        issue(5'h5, 5'h0, 1'b0, 16'h0);
        @(negedge clk);
        chk(source_bus_a, 32'h0000_FFFC ^ 32'hA5A5_0000);
        @(posedge clk);
        instr_multi <= 1'b1;
        issue(5'h0, 5'h7, 1'b0, 16'h0);
        instr_multi <= 1'b0;
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_0080);
        @(posedge clk);
        {instr_valid, instr_src_a} <= {1'b1, 5'h7};
        int_wb_data <= $urandom;
        @(negedge clk);
        chk(instr_issue, 32'h0);
        @(posedge clk);
        int_wb_req <= 1'b1;
        fpu_wb_req <= 1'b1;
        @(negedge clk);
        chk({int_wb_gnt, fpu_wb_gnt}, 32'h2);
        chk(instr_issue, 32'h1);
        @(posedge clk);
        int_wb_req <= 1'b0;
        instr_valid <= 1'b0;
        @(negedge clk);
        chk({int_wb_gnt, fpu_wb_gnt, result_dst}, {2'b01, 5'h8});
        chk(source_bus_a, int_wb_data);
        @(posedge clk);
        fpu_wb_req <= 1'b0;
        for (logic [2:0] m = 3'h7; m != 3'h0; m = m << 1) begin
            @(posedge clk);
            {exc_imprecise, exc_irq, exc_precise} <= m;
            int_wb_req <= 1'b1;
            see(context_freeze);
            chk({fpu_disable, int_wb_gnt}, 32'h2);
            see(exc_ack);
            chk(prefetch_pointer, 32'h1234_5000 + 8 * cause(m));
            chk({prefetch_flush, prefetch_load}, 32'h3);
            @(posedge clk);
            {exc_imprecise, exc_irq, exc_precise} <= 3'h0;
            see(int_wb_gnt);
            @(posedge clk);
            int_wb_req <= 1'b0;
        end
        bus(1'b1, 8'h00, 32'h1);
        ld = $urandom;
        @(posedge clk);
        {instr_call, branch_taken, branch_target} <= {2'b11, ld};
        issue(5'h0, 5'h0, 1'b0, 16'h0);
        {instr_call, branch_taken} <= 2'b00;
        @(negedge clk);
        chk(result_data, 32'h1234_5018);
        chk({27'h0, result_dst}, 32'h1);
        chk(prefetch_pointer, ld);
        chk({prefetch_flush, prefetch_load}, 32'h3);
        @(posedge clk);
        d_reply_err <= 1'b1;
        issue(5'h0, 5'h9, 1'b1, 16'h0040);
        see(exc_ack);
        chk(prefetch_pointer, 32'h1234_5018);
        @(posedge clk);
        d_reply_err <= 1'b0;
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0000_00C9);
        bus(1'b0, 8'h44, 32'h0);
        chk(rd, 32'h0000_0040);
        finish_test();
    end
endmodule
`default_nettype wire
